// file: verilog/video_flywheel_timing.sv
// Video timing flywheel: learns line and frame geometry from TRS ID words,
// keeps pixel and line counters, handles switch-line resync, drives H/V/F.
// Assumes TRS words arrive decoded on sys_clk; lock and sync control are pins.
//
// Behaviour
// RULE_01 - Flywheel runs only in SMPTE mode, idle otherwise.
// RULE_02 - Counters track line length, active length, total and active lines.
// RULE_03 - Standard learned from TRS H/V timing; synced after one full frame.
// RULE_04 - Once synced, incoming TRS timing keeps being compared with counters.
// RULE_05 - Sync control low: counters reload on every TRS ID word.
// RULE_06 - Sync control high: reload after two lines with identical differing timing.
// RULE_07 - Lock or reset low disables; their rise forces reacquire on next TRS.
// RULE_08 - Sync control rise inside active line forces reload at next TRS.
// RULE_09 - Controller holds sync control low one clock to one line in active part.
// RULE_10 - Detected standard triggers automatic resync at its switch line.
// RULE_11 - 525 lines: end of lines 10 and 273, or line 10 progressive.
// RULE_12 - 625 lines: end of lines 6 and 319, or line 6 progressive.
// RULE_13 - 750 lines progressive: end of line 7.
// RULE_14 - 1125 lines: line 7, plus a second-field line when interlaced.
// RULE_15 - Switch lines use the flywheel's own line count.
// RULE_16 - 1125 lines: 24 segmented frame identified, others not separated.
// RULE_17 - H/V/F from received TRS when control low, flywheel when high.
// RULE_18 - Separate H, V and F outputs go to application logic.
// RULE_19 - Blank select low: H high for whole blanking including EAV and SAV.
// RULE_20 - Blank select high: H follows H bit of received TRS words.
// RULE_21 - SMPTE mode entered on TRS with lock, left when TRS stops.
// RULE_22 - A triggered resync also tells word alignment to resync at next TRS.
// RULE_23 - Automatic switch-line resync reloads on next TRS unconditionally.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "video_flywheel_cfg.svh"

module video_flywheel_timing
    import video_flywheel_pkg::*;
#(
    parameter int TRS_TIMEOUT = `TRS_TIMEOUT_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire trs_word_t trs_in,
    input wire logic locked,
    input wire logic flywheel_sync_control,
    output hvf_t hvf_out,
    output logic smpte_mode,
    output logic flywheel_synced,
    output logic align_resync
);

    // --------
    // Reset release and pin synchronisers
    // --------
    logic rst_meta, rst_n_s;
    logic lock_meta, lock_s;
    logic ctrl_meta, ctrl_s, ctrl_d;

    // Reset is asserted at once but released on a clock edge
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n_s <= rst_meta;
        end
    end

    // Lock and sync control come from outside; edges are taken after two flops
    always_ff @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            lock_meta <= 1'b0;
            lock_s <= 1'b0;
            ctrl_meta <= 1'b0;
            ctrl_s <= 1'b0;
            ctrl_d <= 1'b0;
        end else if (clk_en) begin
            lock_meta <= locked;
            lock_s <= lock_meta;
            ctrl_meta <= flywheel_sync_control;
            ctrl_s <= ctrl_meta;
            ctrl_d <= ctrl_s;
        end
    end

    // --------
    // State
    // --------
    fw_state_t state_reg, state_next;
    logic smpte_reg, smpte_next;
    logic [15:0] silence_reg, silence_next;
    logic [`PIX_W-1:0] pix_reg, pix_next, learn_pix_reg, learn_pix_next;
    logic [`PIX_W-1:0] total_len_reg, total_len_next, blank_len_reg, blank_len_next;
    logic [`PIX_W-1:0] err_pos_reg;
    logic [`LINE_W-1:0] line_reg, line_next, rx_line_reg, rx_line_next;
    logic [`LINE_W-1:0] total_lines_reg, total_lines_next;
    logic [`LINE_W-1:0] act_lines_reg, act_cnt_reg, act_cnt_next;
    logic interlaced_reg, f_seen_reg, f_seen_next, prev_v_reg, miss_prev_reg;
    logic [1:0] frames_reg, frames_next;
    logic force_reg, force_next, align_reg;
    logic rx_h_reg, rx_v_reg, rx_f_reg;
    logic hcfg_reg;
    hvf_t hvf_reg, hvf_next;
    logic [1:0] vf_mem [0:`LINE_DEPTH-1];

    // Switch line of the learned standard, in flywheel numbering
    function automatic logic switch_hit(input logic [`LINE_W-1:0] lines,
                                        input logic il,
                                        input logic [`LINE_W-1:0] ln);
        logic hit;
        hit = 1'b0;
        case (lines)
            `LINES_525: hit = (ln == `SW_525_A) || (il && ln == `SW_525_B); // RULE_11
            `LINES_625: hit = (ln == `SW_625_A) || (il && ln == `SW_625_B); // RULE_12
            `LINES_750: hit = (ln == `SW_750_A); // RULE_13
            `LINES_1125: hit = (ln == `SW_1125_A) || (il && ln == `SW_1125_B); // RULE_14
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : switch_hit

    // --------
    // Decoding of the received stream
    // --------
    wire enabled = smpte_reg && lock_s; // RULE_01 RULE_07
    wire rx_eav = trs_in.valid && !trs_in.sav;
    wire rx_sav = trs_in.valid && trs_in.sav;
    wire frame_edge = rx_eav && trs_in.v && !prev_v_reg && !trs_in.f;
    wire synced = (state_reg == FW_SYNCED);
    wire fly_wrap = (pix_reg == total_len_reg - `PIX_W'(1));
    wire fly_active = (pix_reg >= blank_len_reg);
    // Flywheel EAV belongs at pixel zero; anything else is a timing error
    wire mismatch = rx_eav && synced && (pix_reg != '0); // RULE_04
    wire confirm = mismatch && miss_prev_reg && (pix_reg == err_pos_reg); // RULE_06
    wire ctrl_rise = ctrl_s && !ctrl_d;
    wire sw_end = synced && fly_wrap
        && switch_hit(total_lines_reg, interlaced_reg, line_reg); // RULE_10 RULE_15
    wire force_set = !enabled || (ctrl_rise && fly_active) || sw_end; // RULE_07 RULE_08
    wire reload = enabled && trs_in.valid
        && (force_reg || !ctrl_s || confirm); // RULE_05 RULE_06 RULE_23
    wire use_fly = ctrl_s && synced; // RULE_17
    // A lone stray EAV under flywheel timing must not corrupt the learned geometry
    wire rx_take = rx_eav && !(mismatch && use_fly && !reload); // RULE_04 RULE_06
    wire [1:0] fly_vf = vf_mem[line_reg];
    wire psf24 = (total_lines_reg == `LINES_1125)
        && (total_len_reg == `PSF24_LINE_LEN); // RULE_16

    // --------
    // SMPTE mode tracking
    // --------
    // Silence counter drops the mode when TRS words stop arriving
    assign silence_next = trs_in.valid ? '0
        : (silence_reg == 16'(TRS_TIMEOUT) ? silence_reg : silence_reg + 16'h0001);
    assign smpte_next = !lock_s ? 1'b0
        : (trs_in.valid ? 1'b1 : (silence_reg == 16'(TRS_TIMEOUT) ? 1'b0 : smpte_reg)); // RULE_21

    // --------
    // Geometry learning from received TRS timing
    // --------
    // learn_pix counts words since the last received EAV (EAV is word 0)
    assign learn_pix_next = rx_take ? `PIX_W'(1) : learn_pix_reg + `PIX_W'(1);
    assign total_len_next = rx_take ? learn_pix_reg : total_len_reg; // RULE_02
    assign blank_len_next = rx_sav ? learn_pix_reg + `PIX_W'(1) : blank_len_reg; // RULE_02
    assign rx_line_next = !rx_take ? rx_line_reg
        : (frame_edge ? `LINE_W'(1) : rx_line_reg + `LINE_W'(1));
    assign total_lines_next = frame_edge ? rx_line_reg : total_lines_reg; // RULE_02
    assign act_cnt_next = frame_edge ? '0
        : ((rx_take && !trs_in.v) ? act_cnt_reg + `LINE_W'(1) : act_cnt_reg);
    assign f_seen_next = frame_edge ? 1'b0 : (f_seen_reg || (rx_take && trs_in.f));
    assign frames_next = !enabled ? 2'h0
        : ((frame_edge && frames_reg != 2'h2) ? frames_reg + 2'h1 : frames_reg); // RULE_03

    // --------
    // Flywheel counters and the resync decision
    // --------
    // A reload on EAV restarts the line, on SAV lands on the first active word
    assign pix_next = reload ? (rx_eav ? `PIX_W'(1) : learn_pix_reg + `PIX_W'(1))
        : (fly_wrap ? '0 : pix_reg + `PIX_W'(1)); // RULE_02 RULE_05
    assign line_next = (reload && rx_eav) ? rx_line_next
        : (fly_wrap ? (line_reg >= total_lines_reg ? `LINE_W'(1) : line_reg + `LINE_W'(1))
        : line_reg);
    // The trigger wins over the consuming TRS word in the same cycle
    assign force_next = force_set ? 1'b1 : ((enabled && trs_in.valid) ? 1'b0 : force_reg);

    // Learning needs two frame boundaries, i.e. one complete frame between
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            FW_IDLE: begin
                if (enabled) state_next = FW_LEARN;
            end
            FW_LEARN: begin
                if (!enabled) state_next = FW_IDLE;
                else if (frames_reg == 2'h2) state_next = FW_SYNCED; // RULE_03
            end
            FW_SYNCED: begin
                if (!enabled) state_next = FW_IDLE; // RULE_07
            end
            default: state_next = FW_IDLE;
        endcase
    end

    // --------
    // H/V/F selection
    // --------
    // Blank select low keeps H up through the SAV word; high follows the H bit
    wire rx_h = hcfg_reg ? (trs_in.valid ? trs_in.h : rx_h_reg)
        : (trs_in.valid || rx_h_reg); // RULE_19 RULE_20
    wire fly_h = hcfg_reg ? (pix_reg < blank_len_reg - `PIX_W'(1))
        : (pix_reg < blank_len_reg); // RULE_19 RULE_20
    wire rx_v = trs_in.valid ? trs_in.v : rx_v_reg;
    wire rx_f = trs_in.valid ? trs_in.f : rx_f_reg;
    assign hvf_next = !enabled ? hvf_t'(3'h0)
        : (use_fly ? hvf_t'({fly_h, fly_vf}) : hvf_t'({rx_h, rx_v, rx_f})); // RULE_17 RULE_18

    // --------
    // Register bus decode
    // --------
    wire setup = psel && !penable && !pready;
    wire hit_ctl = (paddr == `OFF_PROC_DISABLE);
    wire hit_st = (paddr == `OFF_STATUS);
    wire hit_geo = (paddr == `OFF_GEOMETRY);
    wire mapped = hit_ctl || hit_st || hit_geo;
    wire wr_ctl = psel && penable && pready && pwrite && hit_ctl && !pslverr;
    wire [31:0] st_word = (32'(smpte_reg) << `ST_SMPTE_BIT)
        | (32'(synced) << `ST_SYNCED_BIT)
        | (32'(interlaced_reg) << `ST_INTERLACED_BIT)
        | (32'(psf24) << `ST_PSF24_BIT)
        | (32'(act_lines_reg) << `ST_ACTLINES_LSB)
        | (32'(total_lines_reg) << `ST_TOTLINES_LSB);
    wire [31:0] geo_word = (32'(total_len_reg) << `GEO_TOTLEN_LSB)
        | (32'(total_len_reg - blank_len_reg) << `GEO_ACTLEN_LSB);
    wire [31:0] rd_word = hit_ctl ? (32'(hcfg_reg) << `HCFG_BIT)
        : (hit_st ? st_word : (hit_geo ? geo_word : 32'h0000_0000));

    // --------
    // Flops
    // --------
    // Per-line V/F learned from the stream feeds the flywheel generator
    always_ff @(posedge sys_clk) begin
        if (clk_en && rx_take) vf_mem[rx_line_next] <= {trs_in.v, trs_in.f};
    end

    // Counters and learned geometry
    always_ff @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pix_reg <= '0;
            line_reg <= `LINE_W'(1);
            learn_pix_reg <= '0;
            total_len_reg <= '0;
            blank_len_reg <= '0;
            rx_line_reg <= '0;
            total_lines_reg <= '0;
            act_cnt_reg <= '0;
            f_seen_reg <= 1'b0;
            frames_reg <= 2'h0;
        end else if (clk_en) begin
            pix_reg <= pix_next;
            line_reg <= line_next;
            learn_pix_reg <= learn_pix_next;
            total_len_reg <= total_len_next;
            blank_len_reg <= blank_len_next;
            rx_line_reg <= rx_line_next;
            total_lines_reg <= total_lines_next;
            act_cnt_reg <= act_cnt_next;
            f_seen_reg <= f_seen_next;
            frames_reg <= frames_next;
        end
    end

    // Frame results, error memory and received TRS levels
    always_ff @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            act_lines_reg <= '0;
            interlaced_reg <= 1'b0;
            prev_v_reg <= 1'b0;
            miss_prev_reg <= 1'b0;
            err_pos_reg <= '0;
            rx_h_reg <= 1'b0;
            rx_v_reg <= 1'b0;
            rx_f_reg <= 1'b0;
        end else if (clk_en) begin
            if (frame_edge) act_lines_reg <= act_cnt_reg;
            if (frame_edge) interlaced_reg <= f_seen_reg;
            if (rx_eav) prev_v_reg <= trs_in.v;
            if (rx_eav) miss_prev_reg <= mismatch && !reload; // RULE_06
            if (mismatch) err_pos_reg <= pix_reg;
            rx_h_reg <= rx_h && !(trs_in.valid && !trs_in.h);
            rx_v_reg <= rx_v;
            rx_f_reg <= rx_f;
        end
    end

    // Control state; force starts set so reset release reacquires
    always_ff @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            state_reg <= FW_IDLE;
            smpte_reg <= 1'b0;
            silence_reg <= '0;
            force_reg <= 1'b1;
            align_reg <= 1'b0;
            hvf_reg <= hvf_t'(3'h0);
        end else if (clk_en) begin
            state_reg <= state_next;
            smpte_reg <= smpte_next;
            silence_reg <= silence_next;
            force_reg <= force_next; // RULE_07 RULE_08 RULE_23
            align_reg <= enabled && ((ctrl_rise && fly_active) || sw_end); // RULE_22
            hvf_reg <= hvf_next;
        end
    end

    // Bus slave: no wait states, ready and data are registered
    always_ff @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            hcfg_reg <= `HCFG_RESET;
        end else if (clk_en) begin
            pready <= setup;
            pslverr <= setup && !mapped;
            if (setup) prdata <= rd_word;
            if (wr_ctl) hcfg_reg <= pwdata[`HCFG_BIT];
        end
    end

    assign hvf_out = hvf_reg;
    assign smpte_mode = smpte_reg;
    assign flywheel_synced = (state_reg == FW_SYNCED);
    assign align_resync = align_reg;

endmodule : video_flywheel_timing

// file: pkg/video_flywheel_cfg.svh
// Constants for the video flywheel timing block: offsets, field positions,
// reset values, geometry widths and switch-line numbers.
// Assumes inclusion by bare name from the package and the design file.
`ifndef VIDEO_FLYWHEEL_CFG_SVH
`define VIDEO_FLYWHEEL_CFG_SVH

// --------
// Counter widths
// --------
`define PIX_W 12
`define LINE_W 11
`define LINE_DEPTH 2048

// --------
// Register map (byte addresses on the 8-bit APB address)
// --------
`define ADDR_W 8
`define OFF_PROC_DISABLE 8'h00
`define OFF_STATUS 8'h04
`define OFF_GEOMETRY 8'h08
`define HCFG_BIT 0
`define HCFG_RESET 1'b0

// --------
// Status and geometry field positions
// --------
`define ST_SMPTE_BIT 0
`define ST_SYNCED_BIT 1
`define ST_INTERLACED_BIT 2
`define ST_PSF24_BIT 3
`define ST_ACTLINES_LSB 4
`define ST_TOTLINES_LSB 16
`define GEO_TOTLEN_LSB 0
`define GEO_ACTLEN_LSB 16

// --------
// Video systems and their switch lines (flywheel line numbering)
// --------
`define LINES_525 11'h20d
`define LINES_625 11'h271
`define LINES_750 11'h2ee
`define LINES_1125 11'h465
`define SW_525_A 11'h00a
`define SW_525_B 11'h111
`define SW_625_A 11'h006
`define SW_625_B 11'h13f
`define SW_750_A 11'h007
`define SW_1125_A 11'h007
`define SW_1125_B 11'h239
`define PSF24_LINE_LEN 12'habe

// --------
// Timing
// --------
`define TRS_TIMEOUT_DEFAULT 16384

`endif

// file: pkg/video_flywheel_pkg.sv
// Types shared by the video flywheel timing block and its bench.
// Assumes the constants header sits beside it on the include path.
`include "video_flywheel_cfg.svh"

package video_flywheel_pkg;

    // Decoded TRS ID word as presented by the word aligner
    typedef struct packed {
        logic valid;
        logic sav;
        logic f;
        logic v;
        logic h;
    } trs_word_t;

    // Timing outputs to the application logic
    typedef struct packed {
        logic h;
        logic v;
        logic f;
    } hvf_t;

    typedef enum logic [1:0] {
        FW_IDLE,
        FW_LEARN,
        FW_SYNCED
    } fw_state_t;

endpackage : video_flywheel_pkg

// file: bench/video_source.sv
// Far-side model: a video source of EAV/SAV words plus the application
// logic that drives the sync control pin. Shares sys_clk with the block.
`timescale 1ns/1ps

module video_source
    import video_flywheel_pkg::*;
#(
    parameter int LINE_LEN = 16,
    parameter int BLANK_LEN = 4,
    parameter int LINES = 525,
    parameter int VBLANK = 20
) (
    input wire logic sys_clk,
    input wire logic run,
    input wire logic glitch,
    input wire logic ctl_high,
    input wire logic ctl_pulse,
    output trs_word_t trs_in,
    output logic flywheel_sync_control,
    output int pix,
    output int line_no
);
    int low_cnt = 0;
    logic vb;

    // --------
    // Raster position; line 1 opens the vertical blank
    // --------
    initial begin
        pix = 0;
        line_no = 1;
    end
    always @(posedge sys_clk) begin
        if (run) begin
            pix <= (pix == LINE_LEN - 1) ? 0 : pix + 1;
            if (pix == LINE_LEN - 1) begin
                line_no <= (line_no == LINES) ? 1 : line_no + 1;
            end
        end
        if (ctl_pulse && pix == BLANK_LEN + 2) begin
            low_cnt <= 3;
        end else if (low_cnt != 0) begin
            low_cnt <= low_cnt - 1;
        end
    end

    // EAV at pixel 0, SAV on the last blank pixel; idle fields churn so
    // that a stale word can never be mistaken for a fresh one
    assign vb = (line_no <= VBLANK);
    always_comb begin
        trs_in = '{valid: 1'b0, sav: pix[0], f: pix[1], v: pix[2], h: pix[3]};
        if (run && (pix == 0 || glitch)) begin
            trs_in = '{valid: 1'b1, sav: 1'b0, f: 1'b0, v: vb, h: 1'b1};
        end
        if (run && pix == BLANK_LEN - 1) begin
            trs_in = '{valid: 1'b1, sav: 1'b1, f: 1'b0, v: vb, h: 1'b0};
        end
    end

    // Switch strobe: low three clocks inside the active part of one line
    assign flywheel_sync_control = ctl_high && (low_cnt == 0);
endmodule : video_source

// file: bench/video_flywheel_properties.sv
// Concurrent checks on the flywheel block's ports, bound to its top.
// Assumes one clock domain and the active-low asynchronous nrst.
`timescale 1ns/1ps
`include "video_flywheel_cfg.svh"

module video_flywheel_properties
    import video_flywheel_pkg::*;
#(
    parameter int TRS_TIMEOUT = `TRS_TIMEOUT_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire trs_word_t trs_in,
    input wire logic locked,
    input wire logic flywheel_sync_control,
    input wire hvf_t hvf_out,
    input wire logic smpte_mode,
    input wire logic flywheel_synced,
    input wire logic align_resync
);
    int quiet;
    logic boundary;

    default clocking dcb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // EAV word with V set and F clear, and clocks since the last TRS (saturates)
    assign boundary = trs_in.valid && !trs_in.sav && trs_in.v && !trs_in.f;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            quiet <= 0;
        end else if (trs_in.valid) begin
            quiet <= 0;
        end else if (quiet < TRS_TIMEOUT + 8) begin
            quiet <= quiet + 1;
        end
    end

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence trs_mode_s;
        (smpte_mode && locked && !flywheel_sync_control) [*4];
    endsequence
    sequence eav_s;
        trs_in.valid && !trs_in.sav;
    endsequence

    AST_PREADY_ANSWER: assert property (setup_s |=> pready)
        else $error("no ready in the access cycle");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    AST_ERR_UNMAPPED: assert property (pready |-> pslverr ==
        !(paddr inside {`OFF_PROC_DISABLE, `OFF_STATUS, `OFF_GEOMETRY}))
        else $error("error response does not match the address");
    AST_UNLOCKED_IDLE: assert property (!locked [*6] |->
        hvf_out == 3'b000 && !flywheel_synced) else $error("active while unlocked");
    AST_NO_SMPTE_IDLE: assert property (!smpte_mode [*2] |->
        hvf_out == 3'b000 && !flywheel_synced) else $error("active outside video mode");
    AST_SYNC_AT_FRAME: assert property ($rose(flywheel_synced) |->
        $past(boundary, 2) && smpte_mode) else $error("sync not at a frame start");
    AST_H_FROM_EAV: assert property (trs_mode_s ##0 eav_s |=> hvf_out.h &&
        hvf_out.v == $past(trs_in.v) && hvf_out.f == $past(trs_in.f))
        else $error("timing not taken from the received word");
    AST_RESYNC_PULSE: assert property (align_resync |=> !align_resync)
        else $error("aligner resync longer than one cycle");
    AST_TRS_TIMEOUT: assert property (quiet == TRS_TIMEOUT + 8 |-> !smpte_mode)
        else $error("video mode kept without sync words");
endmodule : video_flywheel_properties

bind video_flywheel_timing video_flywheel_properties #(.TRS_TIMEOUT(TRS_TIMEOUT)) props (
    .sys_clk, .nrst, .psel, .penable, .paddr, .pready, .pslverr, .trs_in, .locked,
    .flywheel_sync_control, .hvf_out, .smpte_mode, .flywheel_synced, .align_resync);

// file: bench/testbench.sv
// Self-checking bench: APB master, video source model, scenario tasks.
// Assumes package, design, source model and checker compiled first.
`timescale 1ns/1ps
`include "video_flywheel_cfg.svh"

module testbench;
    import video_flywheel_pkg::*;

    localparam int LL = 16;
    localparam int NL = 525;
    localparam int TMO = 64;

    logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, locked;
    logic run, glitch, ctl_high, ctl_pulse, fsc, smpte_mode, flywheel_synced, align_resync;
    logic [`ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    trs_word_t trs_in;
    hvf_t hvf_out;
    int pix, line_no;
    int n_mismatch = 0;
    int checks_done = 0;

    video_source src (.sys_clk(sys_clk), .run(run), .glitch(glitch), .ctl_high(ctl_high),
        .ctl_pulse(ctl_pulse), .trs_in(trs_in), .flywheel_sync_control(fsc), .pix(pix),
        .line_no(line_no));

    video_flywheel_timing #(.TRS_TIMEOUT(TMO)) dut (.sys_clk(sys_clk), .nrst(nrst),
        .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trs_in(trs_in), .locked(locked), .flywheel_sync_control(fsc), .hvf_out(hvf_out),
        .smpte_mode(smpte_mode), .flywheel_synced(flywheel_synced),
        .align_resync(align_resync));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic give_verdict;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; r returns {pslverr, prdata} taken at the ready edge
    task automatic apb(input logic wr, input logic [`ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [32:0] r);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : apb

    // Bounded wait for a raster position; samples just after the edge
    task automatic wait_at(input int l, input int p);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (!(line_no == l && pix == p) && n < NL * LL + 50);
        if (n >= NL * LL + 50) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : wait_at

    task automatic s_regs;
        logic [32:0] r;
        repeat (3) @(posedge sys_clk);
        apb(1'b0, `OFF_PROC_DISABLE, 32'h0, r);
        chk(r, 33'h0);
        apb(1'b1, `OFF_PROC_DISABLE, 32'h1, r);
        apb(1'b0, `OFF_PROC_DISABLE, 32'h0, r);
        chk(r, 33'h1);
        apb(1'b1, `OFF_GEOMETRY, 32'hffff_ffff, r);
        chk(r[32], 1'b0);
        apb(1'b0, 8'h0c, 32'h0, r);
        chk(r, 33'h1_0000_0000);
        apb(1'b1, `OFF_PROC_DISABLE, 32'h0, r);
    endtask : s_regs

    task automatic s_lock;
        logic [32:0] r;
        @(posedge sys_clk);
        locked <= 1'b1;
        wait_at(1, 0);
        wait_at(1, 0);
        wait_at(1, 3);
        chk({flywheel_synced, smpte_mode, hvf_out}, 5'b11110);
        apb(1'b0, `OFF_STATUS, 32'h0, r);
        chk(r, 33'h020d_1f93);
        apb(1'b0, `OFF_GEOMETRY, 32'h0, r);
        chk(r, 33'h000c_0010);
    endtask : s_lock

    // H around the SAV word under each blank select setting
    task automatic s_hsel(input logic sel);
        logic [32:0] r;
        apb(1'b1, `OFF_PROC_DISABLE, {31'h0, sel}, r);
        wait_at(70, 1);
        chk(hvf_out.h, 1'b1);
        wait_at(70, 4);
        chk(hvf_out.h, !sel);
        wait_at(70, 10);
        chk({hvf_out.h, hvf_out.v}, 2'b00);
        apb(1'b1, `OFF_PROC_DISABLE, 32'h0, r);
    endtask : s_hsel

    // A stray EAV in mid-line: followed with control low, ignored with it high
    task automatic s_glitch(input int l, input logic exp);
        wait_at(l, 7);
        @(posedge sys_clk);
        glitch <= 1'b1;
        @(posedge sys_clk);
        glitch <= 1'b0;
        #1;
        chk(hvf_out.h, exp);
        wait_at(l + 1, 1);
        chk(hvf_out.h, 1'b1);
    endtask : s_glitch

    // One full frame with control high: one resync, on the line after line 10
    task automatic s_auto;
        int cnt;
        int ln;
        cnt = 0;
        ln = 0;
        // The earlier stray EAV skews one frame's line total; let a clean frame relearn
        wait_at(1, 0);
        wait_at(1, 0);
        repeat (NL * LL) begin
            @(posedge sys_clk);
            #1;
            if (align_resync === 1'b1) begin
                cnt++;
                ln = line_no;
            end
        end
        chk(cnt, 1);
        chk(ln, 11);
    endtask : s_auto

    task automatic s_manual;
        int cnt;
        cnt = 0;
        wait_at(40, 0);
        @(posedge sys_clk);
        ctl_pulse <= 1'b1;
        for (int i = 0; i < 2 * LL; i++) begin
            @(posedge sys_clk);
            if (i == 8) ctl_pulse <= 1'b0;
            #1;
            if (align_resync === 1'b1) cnt++;
        end
        chk(cnt, 1);
    endtask : s_manual

    task automatic s_drop;
        @(posedge sys_clk);
        locked <= 1'b0;
        repeat (8) @(posedge sys_clk);
        #1;
        chk({flywheel_synced, hvf_out}, 4'h0);
        @(posedge sys_clk);
        locked <= 1'b1;
        run <= 1'b0;
        repeat (TMO + 12) @(posedge sys_clk);
        #1;
        chk(smpte_mode, 1'b0);
    endtask : s_drop

    // --------
    // Main sequence
    // --------
    initial begin
        {nrst, psel, penable, pwrite, locked, glitch, ctl_high, ctl_pulse} = 8'h00;
        run = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (16) @(posedge sys_clk);
        chk({hvf_out, smpte_mode, flywheel_synced, pready}, 6'h00);
        nrst <= 1'b1;
        s_regs();
        repeat (3 * LL) @(posedge sys_clk);
        #1;
        chk({smpte_mode, flywheel_synced, hvf_out}, 5'h00);
        s_lock();
        s_hsel(1'b0);
        s_hsel(1'b1);
        s_glitch(100, 1'b1);
        @(posedge sys_clk);
        ctl_high <= 1'b1;
        s_auto();
        s_manual();
        s_glitch(60, 1'b0);
        s_drop();
        give_verdict();
    end
endmodule : testbench
